// File: design/sbc_port.sv
// two-wire slave command port with pointer, write latch and checksum
//
// Summary of operation
// - lines are sampled; the port only pulls low, never drives high
// - transaction: start, 7-bit address plus direction, data bytes, stop
// - both high idle; data fall with clock high start, rise stop
// - one bit per clock pulse, data stable while clock high
// - port pulls data low through the ninth pulse after each received byte, except a foreign address
// - address is 0101, then 0, 1, then the address select pin
// - eighth bit after address: low write, high read
// - first written byte is the command byte, setting the pointer
// - stop right after command byte only updates the pointer
// - only last data byte or word before stop is committed
// - reads start at the pointer, which increments after each byte
// - word read sends low byte then high byte, then checksum if enabled
// - word write: command, low, high, optional checksum, each acked
// - writes accepted with or without trailing checksum; a byte write with one commits as a word
// - read checksum appended unless disabled in first configuration register
// - checksum follows the smbus 1.1 and 2 packet error definition
// - bus stuck over 20 ms after a start resets the port
`timescale 1ns/1ps
module sbc_port
  import sbc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = SBC_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // open-drain bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic scl_out,
  output logic scl_oe,
  // address strap
  input wire logic address_select_pin,
  // read checksum switch from first_configuration_register
  input wire logic pec_read_en,
  // register read side
  output logic [7:0] rd_ptr,
  input wire logic [15:0] rd_word,
  // committed write
  output logic wr_stb,
  output logic [7:0] wr_cmd,
  output logic [7:0] write_low_byte,
  output logic [7:0] write_high_byte,
  output logic wr_is_word,
  // pointer-only update
  output logic ptr_stb
);
  typedef enum logic [2:0] {
    SBC_IDLE, SBC_ADDR, SBC_RX, SBC_RX_ACK, SBC_TX, SBC_TX_ACK, SBC_IGNORE
  } sbc_state_e;

  sbc_line_if ln();
  sbc_line_watch sbc_line_watch_i (
    .ref_clk(ref_clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ev(ln)
  );

  // crc-8 step over one byte, msb first
  function automatic logic [7:0] sbc_crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ SBC_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  sbc_state_e state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic rw_r;
  logic [1:0] rx_idx_r; // bytes after address in write: 0 cmd, 1 low, 2 high, 3 pec
  logic [7:0] ptr_r;
  logic [7:0] low_r;
  logic [7:0] high_r;
  logic [7:0] crc_r;
  logic [1:0] tx_idx_r; // 0 low, 1 high, 2 crc
  logic [7:0] tx_byte_r;
  logic sda_low_r;
  logic [31:0] tmo_cnt_r;
  logic tmo_hit;
  logic [7:0] rx_byte;
  logic addr_match;

  assign rx_byte = {shift_r[6:0], ln.sda_val};
  assign addr_match = rx_byte[7:1] == {SBC_ADDR_HI, SBC_ADDR_MID, address_select_pin};

  // clock line is never pulled: no stretching
  assign scl_out = 1'b0;
  assign scl_oe = 1'b0;
  assign sda_out = 1'b0;
  assign sda_oe = sda_low_r;
  assign rd_ptr = ptr_r;

  // stuck-bus watchdog: counts while busy, cleared by any clock edge
  always_ff @(posedge ref_clk) begin
    if (rst || !ln.bus_busy || ln.scl_rise || ln.scl_fall) begin
      tmo_cnt_r <= 32'h0;
    end else if (!tmo_hit) begin
      tmo_cnt_r <= tmo_cnt_r + 32'h1;
    end
  end
  assign tmo_hit = tmo_cnt_r >= TIMEOUT_CYC;

  // main protocol sequencer, bits shifted on clock rise
  always_ff @(posedge ref_clk) begin
    if (rst || tmo_hit) begin
      state_r <= SBC_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h0;
      rw_r <= 1'b0;
      tx_idx_r <= 2'h0;
      crc_r <= SBC_CRC_INIT;
    end else if (ln.start_det) begin
      // repeated start keeps the running checksum of the write part
      state_r <= SBC_ADDR;
      bit_cnt_r <= 4'h0;
      if (state_r == SBC_IDLE || state_r == SBC_IGNORE || !ln.bus_busy) begin
        crc_r <= SBC_CRC_INIT;
      end
    end else if (ln.stop_det) begin
      state_r <= SBC_IDLE;
    end else if (ln.scl_rise) begin
      unique case (state_r)
        SBC_IDLE, SBC_IGNORE: begin
        end
        SBC_ADDR, SBC_RX: begin
          shift_r <= rx_byte;
          if (bit_cnt_r == 4'h7) begin
            crc_r <= sbc_crc8(crc_r, rx_byte);
            if (state_r == SBC_ADDR) begin
              if (addr_match) begin
                rw_r <= ln.sda_val;
                tx_idx_r <= 2'h0;
                state_r <= SBC_RX_ACK;
              end else begin
                state_r <= SBC_IGNORE;
              end
            end else begin
              state_r <= SBC_RX_ACK;
            end
          end else begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
        end
        SBC_RX_ACK: begin
          bit_cnt_r <= 4'h0;
          if (rw_r && shift_r[7:1] == {SBC_ADDR_HI, SBC_ADDR_MID, address_select_pin}
              && bit_cnt_r == 4'h7) begin
            state_r <= SBC_TX; // address ack for a read
          end else begin
            state_r <= SBC_RX;
            if (!(shift_r[0] == 1'b0 && bit_cnt_r == 4'h7 && state_r == SBC_RX_ACK &&
                rx_idx_r == 2'h0 && tx_idx_r == 2'h3)) begin
            end
          end
        end
        SBC_TX: begin
          if (bit_cnt_r == 4'h7) begin
            crc_r <= sbc_crc8(crc_r, tx_byte_r);
            state_r <= SBC_TX_ACK;
          end else begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
        end
        SBC_TX_ACK: begin
          bit_cnt_r <= 4'h0;
          // saturate so reads past the checksum keep sending ones
          tx_idx_r <= (tx_idx_r == 2'h3) ? 2'h3 : tx_idx_r + 2'h1;
          // not-acknowledge from master ends our sending
          state_r <= ln.sda_val ? SBC_IGNORE : SBC_TX;
        end
        default: state_r <= SBC_IDLE;
      endcase
    end
  end

  // write-side byte sorting: command, low, high, checksum
  always_ff @(posedge ref_clk) begin
    if (rst || tmo_hit) begin
      ptr_r <= SBC_PTR_RST;
      low_r <= 8'h0;
      high_r <= 8'h0;
    end else if (ln.scl_rise && state_r == SBC_RX && bit_cnt_r == 4'h7) begin
      unique case (rx_idx_r)
        2'h0: ptr_r <= rx_byte;
        2'h1: low_r <= rx_byte;
        2'h2: high_r <= rx_byte;
        2'h3: begin
        end
      endcase
    end else if (ln.scl_rise && state_r == SBC_TX_ACK) begin
      ptr_r <= ptr_r + 8'h1;
    end
  end

  // byte index advance at the eighth bit of each received byte
  logic [1:0] rx_idx_nxt;
  assign rx_idx_nxt = (rx_idx_r == 2'h3) ? 2'h3 : rx_idx_r + 2'h1;
  logic rx_data_ack;
  assign rx_data_ack = ln.scl_fall && state_r == SBC_RX && bit_cnt_r == 4'h0 && sda_low_r;

  logic [1:0] rx_cnt_r; // data bytes seen in this write, saturating
  always_ff @(posedge ref_clk) begin
    if (rst || tmo_hit || ln.start_det) begin
      rx_cnt_r <= 2'h0;
    end else if (ln.scl_rise && state_r == SBC_RX && bit_cnt_r == 4'h7 && !rw_r) begin
      rx_cnt_r <= rx_idx_nxt;
    end
  end

  // commit on stop: pointer only, byte, or word; a checksum byte after the high byte ignored
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_stb <= 1'b0;
      ptr_stb <= 1'b0;
      wr_cmd <= 8'h0;
      write_low_byte <= 8'h0;
      write_high_byte <= 8'h0;
      wr_is_word <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      ptr_stb <= 1'b0;
      if (ln.stop_det && !rw_r && state_r != SBC_IDLE && state_r != SBC_IGNORE) begin
        if (rx_cnt_r == 2'h1) begin
          ptr_stb <= 1'b1;
        end else if (rx_cnt_r != 2'h0) begin
          wr_stb <= 1'b1;
          wr_cmd <= ptr_r;
          write_low_byte <= low_r;
          write_high_byte <= high_r;
          wr_is_word <= rx_cnt_r != 2'h2;
        end
      end
    end
  end

  // index tracking: rx_idx advances once per received data byte
  always_ff @(posedge ref_clk) begin
    if (rst || tmo_hit) begin
      rx_idx_r <= 2'h0;
    end else if (ln.scl_rise && state_r == SBC_ADDR) begin
      rx_idx_r <= 2'h0;
    end else if (ln.scl_rise && state_r == SBC_RX && bit_cnt_r == 4'h7) begin
      rx_idx_r <= rx_idx_nxt;
    end
  end

  // transmit byte selection: low, high, then checksum if enabled
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_byte_r <= 8'h0;
    end else if (state_r != SBC_TX || bit_cnt_r == 4'h0 && ln.scl_fall == 1'b0) begin
      unique case (tx_idx_r)
        2'h0: tx_byte_r <= rd_word[7:0];
        2'h1: tx_byte_r <= rd_word[15:8];
        default: tx_byte_r <= crc_r;
      endcase
    end
  end

  logic tx_done;
  // without checksum the master should stop after two bytes; extra reads send ones
  assign tx_done = (tx_idx_r == 2'h2 && !pec_read_en) || tx_idx_r == 2'h3;

  // data line driver, set only on clock fall so it is stable while high; start, stop and timeout release it
  always_ff @(posedge ref_clk) begin
    if (rst || tmo_hit || ln.start_det || ln.stop_det) begin
      sda_low_r <= 1'b0;
    end else if (ln.scl_fall) begin
      unique case (state_r)
        SBC_RX_ACK: sda_low_r <= 1'b1;
        SBC_TX: sda_low_r <= !tx_done && !tx_byte_r[3'(7 - bit_cnt_r)];
        default: sda_low_r <= 1'b0;
      endcase
    end
  end

  ack_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ln.scl_rise && state_r == SBC_RX_ACK) |-> sda_oe)
    else $error("ack not driven at ninth pulse");
  stable_high_a: assert property (@(posedge ref_clk) disable iff (rst)
    (scl_in && $past(scl_in) && !$past(ln.start_det) && !$past(ln.stop_det)
     && !$past(tmo_hit)) |-> $stable(sda_oe))
    else $error("data drive changed with clock high");
  pull_only_a: assert property (@(posedge ref_clk) disable iff (rst)
    sda_oe |-> sda_out == 1'b0)
    else $error("data line driven high");
  stop_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
    ln.stop_det |=> state_r == SBC_IDLE && !sda_oe)
    else $error("stop did not free the port");
  ptr_only_a: assert property (@(posedge ref_clk) disable iff (rst)
    ptr_stb |-> !wr_stb && $past(rx_cnt_r) == 2'h1)
    else $error("pointer update committed data");
  commit_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_stb |-> $past(ln.stop_det))
    else $error("write committed before stop");
  ptr_inc_a: assert property (@(posedge ref_clk) disable iff (rst || tmo_hit)
    (ln.scl_rise && state_r == SBC_TX_ACK) |=> ptr_r == $past(ptr_r) + 8'h1)
    else $error("pointer did not advance after read byte");
  addr_ignore_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ln.scl_rise && state_r == SBC_ADDR && bit_cnt_r == 4'h7 && !addr_match
     && !ln.start_det && !ln.stop_det && !tmo_hit) |=> state_r == SBC_IGNORE)
    else $error("foreign address accepted");
  timeout_a: assert property (@(posedge ref_clk) disable iff (rst)
    tmo_hit |=> state_r == SBC_IDLE && !sda_oe)
    else $error("stuck bus did not reset port");

  // line pull and release around the acknowledge slots
  ack_slot_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ln.scl_fall && state_r == SBC_RX_ACK && !ln.start_det && !ln.stop_det
     && !tmo_hit) |=> sda_oe)
    else $error("ack not pulled after eighth bit");
  rx_release_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ln.scl_fall && state_r == SBC_RX) |=> !sda_oe)
    else $error("data line held while receiving");
  master_ack_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ln.scl_fall && state_r == SBC_TX_ACK) |=> !sda_oe)
    else $error("port drove the master acknowledge");
  foreign_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
    state_r == SBC_IGNORE |-> !sda_oe)
    else $error("ignored frame still pulled");

  // checksum seed and watchdog idle behaviour
  crc_seed_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ln.start_det && state_r == SBC_IDLE && !tmo_hit) |=> crc_r == SBC_CRC_INIT)
    else $error("checksum not seeded at start");
  idle_timer_a: assert property (@(posedge ref_clk) disable iff (rst)
    !ln.bus_busy |=> tmo_cnt_r == 32'h0)
    else $error("lockup timer ran on idle bus");

  // committed write fields move only with their strobe
  commit_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    !wr_stb |-> $stable(wr_cmd) && $stable(write_low_byte) && $stable(write_high_byte))
    else $error("write fields changed without strobe");
  one_strobe_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_stb |=> !wr_stb)
    else $error("write strobe longer than one cycle");
endmodule

// File: pkg/sbc_pkg.sv
// shared constants and types for the smbus command port
package sbc_pkg;
  localparam int unsigned SBC_CLK_HZ = 200000000;
  localparam int unsigned SBC_TIMEOUT_MS = 20;
  // longest hang before the port restarts, in cycles
  localparam int unsigned SBC_TIMEOUT_CYC = SBC_CLK_HZ / 1000 * SBC_TIMEOUT_MS;
  localparam logic [3:0] SBC_ADDR_HI = 4'h5;
  localparam logic [1:0] SBC_ADDR_MID = 2'h1;
  localparam logic [7:0] SBC_CRC_POLY = 8'h07;
  localparam logic [7:0] SBC_CRC_INIT = 8'h00;
  localparam logic [7:0] SBC_PTR_RST = 8'h00;
  localparam int unsigned SBC_ACK_BIT = 8;
  typedef enum logic [1:0] {SBC_EV_NONE, SBC_EV_START, SBC_EV_STOP} sbc_ev_e;
endpackage

// File: pkg/sbc_line_if.sv
// sampled line events passed from the line watcher to the port
`timescale 1ns/1ps
interface sbc_line_if;
  logic scl_rise;
  logic scl_fall;
  logic sda_val;
  logic start_det;
  logic stop_det;
  logic bus_busy;
  modport watcher (output scl_rise, output scl_fall, output sda_val, output start_det,
    output stop_det, output bus_busy);
  modport port (input scl_rise, input scl_fall, input sda_val, input start_det,
    input stop_det, input bus_busy);
endinterface

// File: design/sbc_line_watch.sv
// edge and start/stop detection on the two bus lines
`timescale 1ns/1ps
module sbc_line_watch
  import sbc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // sampled lines
  input wire logic scl_in,
  input wire logic sda_in,
  // events
  sbc_line_if.watcher ev
);
  logic scl_d_r;
  logic sda_d_r;
  logic busy_r;

  // one cycle history of both lines, loaded from the pins during reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // follow the pins so leaving reset in mid-frame shows no false edge
      scl_d_r <= scl_in;
      sda_d_r <= sda_in;
    end else begin
      scl_d_r <= scl_in;
      sda_d_r <= sda_in;
    end
  end

  assign ev.scl_rise = scl_in & ~scl_d_r;
  assign ev.scl_fall = ~scl_in & scl_d_r;
  assign ev.sda_val = sda_in;
  // data edge while clock high marks start or stop
  assign ev.start_det = scl_in & scl_d_r & sda_d_r & ~sda_in;
  assign ev.stop_det = scl_in & scl_d_r & ~sda_d_r & sda_in;

  // bus busy from start to stop
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy_r <= 1'b0;
    end else if (ev.start_det) begin
      busy_r <= 1'b1;
    end else if (ev.stop_det) begin
      busy_r <= 1'b0;
    end
  end
  assign ev.bus_busy = busy_r;

  start_edge_a: assert property (@(posedge ref_clk) disable iff (rst)
    (scl_in && $past(scl_in) && $fell(sda_in)) |=> busy_r)
    else $error("start not flagged busy");
endmodule

// File: testbench/sbc_master_model.sv
// two-wire bus master model for the far side of the port
`timescale 1ns/1ps
module sbc_master_model (
  // clock
  input wire logic ref_clk,
  // resolved data line
  input wire logic sda_bus,
  // line drive, 1 releases to pull-up
  output logic scl_m,
  output logic sda_m
);
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  // quarter bit; moves land on falling edges, away from sampling
  task automatic q();
    repeat (4) @(negedge ref_clk);
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    sda_m = 1'b1;
    q();
    scl_m = 1'b1;
    q();
    sda_m = 1'b0;
    q();
    scl_m = 1'b0;
    q();
  endtask
  // stop: data rises while clock high
  task automatic stop();
    sda_m = 1'b0;
    q();
    scl_m = 1'b1;
    q();
    sda_m = 1'b1;
    q();
  endtask
  // one bit per pulse, data held through the high phase
  task automatic xfer(input logic b, output logic r);
    sda_m = b;
    q();
    scl_m = 1'b1;
    q();
    r = sda_bus;
    q();
    scl_m = 1'b0;
    q();
  endtask
  // byte out msb first, ninth pulse released for the ack
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(d[i], r);
    end
    xfer(1'b1, r);
    ack = (r === 1'b0);
  endtask
  // byte in; master answers ack, or nack on the last byte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1, d[i]);
    end
    xfer(last, r);
  endtask
endmodule

// File: testbench/smbus_slave_command_port_bench.sv
// self-checking bench for the smbus command port
`timescale 1ns/1ps
module smbus_slave_command_port_bench;
  localparam int unsigned TO_CYC = 200;
  typedef struct {logic pin; logic [7:0] addr; logic ack;} sbc_row_s;
  // strap level, address byte, expected acknowledge
  sbc_row_s rows[6] = '{'{1'b0, 8'h54, 1'b1}, '{1'b0, 8'h56, 1'b0}, '{1'b1, 8'h56, 1'b1},
    '{1'b1, 8'h54, 1'b0}, '{1'b0, 8'h5c, 1'b0}, '{1'b1, 8'h16, 1'b0}};
  logic ref_clk, rst, address_select_pin, pec_read_en, scl_m, sda_m, scl_in, sda_in;
  logic sda_out, sda_oe, scl_out, scl_oe, wr_stb, wr_is_word, ptr_stb, r;
  logic [7:0] rd_ptr, wr_cmd, write_low_byte, write_high_byte;
  logic [15:0] rd_word;
  int n_errors = 0;
  int n_compared = 0;
  int n_wr = 0;
  int n_ptr = 0;
  // open-drain wires: anyone pulling low wins
  assign scl_in = scl_m & (scl_oe ? scl_out : 1'b1);
  assign sda_in = sda_m & (sda_oe ? sda_out : 1'b1);
  // register contents: high byte fixed so pointer steps cannot blur it
  assign rd_word = {8'hc3, rd_ptr ^ 8'h5a};
  sbc_port #(.TIMEOUT_CYC(TO_CYC)) sbc_port_i (.ref_clk(ref_clk), .rst(rst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .scl_out(scl_out), .scl_oe(scl_oe), .address_select_pin(address_select_pin),
    .pec_read_en(pec_read_en), .rd_ptr(rd_ptr), .rd_word(rd_word), .wr_stb(wr_stb),
    .wr_cmd(wr_cmd), .write_low_byte(write_low_byte), .write_high_byte(write_high_byte),
    .wr_is_word(wr_is_word), .ptr_stb(ptr_stb));
  sbc_master_model sbc_master_model_i (.ref_clk(ref_clk), .sda_bus(sda_in),
    .scl_m(scl_m), .sda_m(sda_m));
  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // strobe counters
  always @(posedge ref_clk) begin
    if (wr_stb === 1'b1) n_wr++;
    if (ptr_stb === 1'b1) n_ptr++;
  end
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ((x << 1) ^ 8'h07) : (x << 1);
    end
    return x;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic send(input logic [7:0] d, input logic exp);
    logic a;
    sbc_master_model_i.wbyte(d, a);
    chk(16'(a), 16'(exp), "ack");
  endtask
  // write to address 54h: command then n-1 further bytes, then stop
  task automatic write_tx(input logic [7:0] b[5], input int n);
    n_wr = 0;
    n_ptr = 0;
    sbc_master_model_i.start();
    send(8'h54, 1'b1);
    for (int i = 0; i < n; i++) begin
      send(b[i], 1'b1);
    end
    sbc_master_model_i.stop();
    repeat (4) @(negedge ref_clk);
  endtask
  // set pointer, repeated start, read the word and maybe the checksum
  task automatic read_tx(input logic [7:0] cmd, input logic pec);
    logic [7:0] lo, hi, pk, c;
    pec_read_en = pec;
    sbc_master_model_i.start();
    send(8'h54, 1'b1);
    send(cmd, 1'b1);
    sbc_master_model_i.start();
    send(8'h55, 1'b1);
    sbc_master_model_i.rbyte(1'b0, lo);
    sbc_master_model_i.rbyte(!pec, hi);
    if (pec) sbc_master_model_i.rbyte(1'b1, pk);
    sbc_master_model_i.stop();
    c = crc8(crc8(crc8(crc8(crc8(8'h00, 8'h54), cmd), 8'h55), cmd ^ 8'h5a), 8'hc3);
    chk({hi, lo}, {8'hc3, cmd ^ 8'h5a}, "read word");
    if (pec) chk(16'(pk), 16'(c), "read checksum");
    chk(16'(rd_ptr), 16'(cmd + 8'(pec ? 3 : 2)), "pointer step");
    $display("read test done, checksum %0d", pec);
  endtask
  // main sequence
  initial begin
    logic [7:0] c;
    rst = 1'b1;
    address_select_pin = 1'b0;
    pec_read_en = 1'b1;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({4'h0, sda_out, scl_oe, scl_out, sda_oe, rd_ptr}, 16'h0000, "reset outputs");
    rst = 1'b0;
    foreach (rows[i]) begin
      address_select_pin = rows[i].pin;
      sbc_master_model_i.start();
      send(rows[i].addr, rows[i].ack);
      sbc_master_model_i.stop();
    end
    address_select_pin = 1'b0;
    $display("address test done");
    write_tx('{8'h09, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
    chk(16'(n_ptr), 16'h1, "pointer strobe");
    chk(16'(n_wr), 16'h0, "no commit");
    chk(16'(rd_ptr), 16'h09, "pointer");
    $display("pointer test done");
    c = crc8(crc8(crc8(crc8(8'h00, 8'h54), 8'h03), 8'h34), 8'h12);
    write_tx('{8'h03, 8'h34, 8'h12, c, 8'h00}, 4);
    chk(16'(n_wr), 16'h1, "word commit");
    chk({wr_cmd, 7'h00, wr_is_word}, 16'h0301, "word kind");
    chk({write_high_byte, write_low_byte}, 16'h1234, "word data");
    write_tx('{8'h05, 8'haa, 8'h00, 8'h00, 8'h00}, 2);
    chk(16'(n_wr), 16'h1, "byte commit");
    chk({wr_cmd, write_low_byte}, 16'h05aa, "byte data");
    chk(16'(wr_is_word), 16'h0, "byte kind");
    write_tx('{8'h04, 8'h78, 8'h56, 8'h00, 8'h00}, 3);
    chk({wr_cmd, 7'h00, wr_is_word}, 16'h0401, "plain word");
    chk({write_high_byte, write_low_byte}, 16'h5678, "plain data");
    $display("write test done");
    read_tx(8'h02, 1'b1);
    read_tx(8'h08, 1'b0);
    // stall in the ack slot until the lockup timer fires
    sbc_master_model_i.start();
    for (int i = 7; i >= 0; i--) begin
      sbc_master_model_i.xfer(1'(8'h54 >> i), r);
    end
    repeat (4) @(negedge ref_clk);
    chk(16'(sda_oe), 16'h1, "ack pull");
    repeat (TO_CYC + 20) @(negedge ref_clk);
    chk(16'(sda_oe), 16'h0, "lockup release");
    sbc_master_model_i.stop();
    write_tx('{8'h01, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
    chk(16'(rd_ptr), 16'h01, "after lockup");
    $display("timeout test done");
    // reset in mid-frame while the ack is pulled
    sbc_master_model_i.start();
    for (int i = 7; i >= 0; i--) begin
      sbc_master_model_i.xfer(1'(8'h54 >> i), r);
    end
    repeat (4) @(negedge ref_clk);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk({7'h00, sda_oe, rd_ptr}, 16'h0000, "mid reset");
    rst = 1'b0;
    sbc_master_model_i.stop();
    write_tx('{8'h07, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
    chk(16'(rd_ptr), 16'h07, "after reset");
    $display("reset test done");
    print_verdict();
  end
  // watchdog
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_errors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule
